// ---- ibc_bit_counter.v ----
// serial transmit bit counter with transmit interrupt enables and apb registers
//
// How it works
// - the 3-bit count field sets the length of the next frame.
// - reading the count field returns bits still remaining in the current frame.
// - in two-wire format one acknowledge bit follows the data bits.
// - count field returns to zero when a frame, acknowledge included, ends.
// - sync format: code zero means eight bits, codes one to seven that many.
// - empty request is the empty flag gated by its enable.
// - end flag set on the last clock rise of a frame while transmit is empty.
// - end request drops when its flag or its enable is cleared.
// - both transmit enables are zero after reset.
// - count written only when the same write clears write protect.
`include "ibc_defs.vh"
`default_nettype none
module ibc_bit_counter #(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
) (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire sclIn,
   input wire sdaIn,
   output wire sdaOut,
   output wire sdaOe,
   output wire txEmptyRequest,
   output wire txEndRequest
);
   // register state
   reg [2:0] xferCount_q;
   reg msbSel_q;
   reg waitSel_q;
   reg txEmptyIrqEnable_q;
   reg txEndIrqEnable_q;
   reg txEndFlag_q;
   reg i2cFormat_q;
   // link side
   reg [2:0] sclSync_q;
   reg [1:0] sdaSync_q;
   reg [1:0] state_q;
   reg [3:0] remain_q;
   reg [7:0] shift_q;
   reg ackSeen_q;
   reg riseSeen_q;
   reg sdaOut_q;
   // bus decode
   wire setup;
   wire access;
   wire wrDone;
   wire hitMode;
   wire hitIrq;
   wire hitStatus;
   wire hitData;
   wire hitCtrl;
   wire mapped;
   // link decode and fifo handshake
   wire fifoInReady;
   wire fifoOutValid;
   wire [7:0] fifoOutData;
   wire fifoPop;
   wire sclRise;
   wire sclFall;
   wire txEmptyFlag;
   wire frameEnd;
   wire [2:0] countView;
   wire [3:0] frameLen;
   wire [7:0] revData;
   reg [31:0] readMux;

   // apb phases and exact address decode
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hitMode = (paddr == `IBC_OFS_MODE);
   assign hitIrq = (paddr == `IBC_OFS_IRQEN);
   assign hitStatus = (paddr == `IBC_OFS_STATUS);
   assign hitData = (paddr == `IBC_OFS_TXDATA);
   assign hitCtrl = (paddr == `IBC_OFS_CTRL);
   assign mapped = hitMode || hitIrq || hitStatus || hitData || hitCtrl;

   // data writes stall while the fifo is full, so the source really waits
   // every other access answers in its first access cycle
   assign pready = !(pwrite && hitData && !fifoInReady);
   assign pslverr = access && !mapped;
   assign wrDone = access && pwrite && pready && mapped;

   // transmit byte queue between the bus and the shifter
   ibc_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) txFifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .inValid(access && pwrite && hitData),
      .inReady(fifoInReady),
      .inData(pwdata[7:0]),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );

   // transmit side counts as empty while the fifo can take another byte
   // so the empty request drops only once every slot holds data
   assign txEmptyFlag = fifoInReady;

   // pin inputs pass two flops; the third stage only feeds edge detection
   // reset to the released level; a clock resting low gives one fall, ignored in idle
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSync_q <= 3'h7;
         sdaSync_q <= 2'h3;
      end else begin
         sclSync_q <= {sclSync_q[1:0], sclIn};
         sdaSync_q <= {sdaSync_q[0], sdaIn};
      end
   end

   assign sclRise = sclSync_q[1] && !sclSync_q[2];
   assign sclFall = !sclSync_q[1] && sclSync_q[2];

   // zero code means a full byte in both formats
   // a count of zero can never mean an empty frame
   assign frameLen = (xferCount_q == 3'h0) ? `IBC_FULL_FRAME : {1'b0, xferCount_q};

   // bit-reversed copy of the queue head for lsb-first frames;
   // one shifter then serves both orders
   genvar revIdx;
   generate
      for (revIdx = 0; revIdx < 8; revIdx = revIdx + 1) begin : g_rev
         assign revData[revIdx] = fifoOutData[7 - revIdx];
      end
   endgenerate

   // a new byte is taken only between frames
   // the length is copied at load, so the count field is free again at once
   assign fifoPop = (state_q == `IBC_ST_IDLE) && fifoOutValid;

   // last data rise in sync format, the acknowledge rise in two-wire format
   // the count reload and the end flag both key off this one strobe
   assign frameEnd = sclRise && (
      ((state_q == `IBC_ST_SHIFT) && (remain_q == 4'h1) && !i2cFormat_q) ||
      (state_q == `IBC_ST_ACK));

   // frame sequencer: decrement on each rise, move data on each fall
   // a fall before the first rise closes the previous frame and must not shift
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= `IBC_ST_IDLE;
         remain_q <= 4'h0;
         shift_q <= 8'h00;
         riseSeen_q <= 1'b0;
         ackSeen_q <= 1'b0;
      end else begin
         case (state_q)
            `IBC_ST_IDLE: begin
               if (fifoPop) begin
                  // lsb-first is reversed once at load to keep one shifter
                  shift_q <= msbSel_q ? revData : fifoOutData;
                  riseSeen_q <= 1'b0;
                  // length copied now, so a later count write never resizes this frame
                  remain_q <= frameLen;
                  state_q <= `IBC_ST_SHIFT;
               end
            end
            `IBC_ST_SHIFT: begin
               if (sclRise) begin
                  remain_q <= remain_q - 4'h1;
                  riseSeen_q <= 1'b1;
                  if (remain_q == 4'h1) begin
                     // two-wire frames go on to the acknowledge clock
                     state_q <= i2cFormat_q ? `IBC_ST_ACK : `IBC_ST_IDLE;
                  end
               end else if (sclFall && riseSeen_q) begin
                  // next bit onto the line
                  shift_q <= {shift_q[6:0], 1'b0};
               end
            end
            `IBC_ST_ACK: begin
               if (sclRise) begin
                  // sampled on the acknowledge rise; a released line reads high
                  ackSeen_q <= sdaSync_q[1];
                  state_q <= `IBC_ST_IDLE;
               end
            end
            default: begin
               // unused code falls back to idle
               state_q <= `IBC_ST_IDLE;
            end
         endcase
      end
   end

   // two-wire pins are open drain; sync format drives both levels;
   // the level comes from a flop so the pin never shows a mux glitch
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdaOut_q <= 1'b0;
      end else begin
         sdaOut_q <= i2cFormat_q ? 1'b0 : shift_q[7];
      end
   end

   assign sdaOut = sdaOut_q;
   // enable follows the state at once, the data flop lags it by a cycle
   assign sdaOe = (state_q == `IBC_ST_SHIFT) && (!i2cFormat_q || !shift_q[7]);

   // during a frame the count field shows bits still to go
   // eight remaining reads back as zero, the code that selects eight
   assign countView = (state_q == `IBC_ST_IDLE) ? xferCount_q : remain_q[2:0];

   // mode, enable and control registers
   // wait select is kept for software only; nothing here inserts waits
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         xferCount_q <= `IBC_RST_COUNT;
         msbSel_q <= 1'b0;
         waitSel_q <= 1'b0;
         txEmptyIrqEnable_q <= 1'b0;
         txEndIrqEnable_q <= 1'b0;
         i2cFormat_q <= `IBC_RST_CTRL;
      end else begin
         if (wrDone && hitMode) begin
            msbSel_q <= pwdata[`IBC_MODE_MSBSEL];
            waitSel_q <= pwdata[`IBC_MODE_WAIT];
         end
         // only a real count write, not a protected one, displaces the reload
         if (wrDone && hitMode && !pwdata[`IBC_MODE_PROT]) begin
            xferCount_q <= pwdata[2:0];
         end else if (frameEnd) begin
            xferCount_q <= 3'h0;
         end
         if (wrDone && hitIrq) begin
            txEmptyIrqEnable_q <= pwdata[`IBC_IRQ_TXEMPTY];
            txEndIrqEnable_q <= pwdata[`IBC_IRQ_TXEND];
         end
         if (wrDone && hitCtrl) begin
            i2cFormat_q <= pwdata[`IBC_CTRL_I2C];
         end
      end
   end

   // end flag: frame end with nothing queued sets it, write-one clears it;
   // a set in the same cycle as a clear wins so no event is lost
   // a queued byte defers the flag to the end of the last frame
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txEndFlag_q <= 1'b0;
      end else if (frameEnd && !fifoOutValid && txEmptyFlag) begin
         txEndFlag_q <= 1'b1;
      end else if (wrDone && hitStatus && pwdata[`IBC_ST_TXEND]) begin
         txEndFlag_q <= 1'b0;
      end
   end

   // requests are plain levels of flag and enable
   // no extra flop, so a cleared enable takes effect in the same cycle
   assign txEmptyRequest = txEmptyFlag && txEmptyIrqEnable_q;
   assign txEndRequest = txEndFlag_q && txEndIrqEnable_q;

   // read mux; protect bit and the two fixed bits always read one
   // decode is exact, so unmapped offsets read zero
   always @* begin
      readMux = 32'h0000_0000;
      if (hitMode) begin
         readMux[7:0] = `IBC_MODE_FIXED | {msbSel_q, waitSel_q, 2'b00, 1'b1, countView};
      end else if (hitIrq) begin
         readMux[`IBC_IRQ_TXEMPTY] = txEmptyIrqEnable_q;
         readMux[`IBC_IRQ_TXEND] = txEndIrqEnable_q;
      end else if (hitStatus) begin
         readMux[`IBC_ST_TXEMPTY] = txEmptyFlag;
         readMux[`IBC_ST_TXEND] = txEndFlag_q;
         readMux[1] = ackSeen_q;
         readMux[0] = (state_q != `IBC_ST_IDLE);
      end else if (hitCtrl) begin
         readMux[`IBC_CTRL_I2C] = i2cFormat_q;
      end
   end

   // read data captured in the setup cycle and held through the access
   // a read therefore sees state as of its setup cycle
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= readMux;
      end
   end
endmodule // ibc_bit_counter
`default_nettype wire

// ---- ibc_defs.vh ----
// register offsets, field positions and reset values for the serial bit counter block
`ifndef IBC_DEFS_VH
`define IBC_DEFS_VH
`define IBC_OFS_MODE 12'h000
`define IBC_OFS_IRQEN 12'h004
`define IBC_OFS_STATUS 12'h008
`define IBC_OFS_TXDATA 12'h00C
`define IBC_OFS_CTRL 12'h010
`define IBC_MODE_MSBSEL 7
`define IBC_MODE_WAIT 6
`define IBC_MODE_PROT 3
`define IBC_MODE_FIXED 8'h30
`define IBC_IRQ_TXEMPTY 7
`define IBC_IRQ_TXEND 6
`define IBC_ST_TXEMPTY 7
`define IBC_ST_TXEND 6
`define IBC_CTRL_I2C 0
`define IBC_RST_COUNT 3'h0
`define IBC_RST_CTRL 1'b1
`define IBC_FULL_FRAME 4'h8
`define IBC_ST_IDLE 2'h0
`define IBC_ST_SHIFT 2'h1
`define IBC_ST_ACK 2'h2
`endif

// ---- ibc_fifo.v ----
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module ibc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire ref_clk,
   input wire rst_n,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] level_q;
   wire push;
   wire pop;

   // full and empty come straight from the fill level
   assign inReady = (level_q != DEPTH[AW:0]);
   assign outValid = (level_q != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // storage has no reset; only the pointers matter
   always @(posedge ref_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers wrap at depth, which must be a power of two
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         level_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (push && !pop) begin
            level_q <= level_q + 1'b1;
         end else if (pop && !push) begin
            level_q <= level_q - 1'b1;
         end
      end
   end
endmodule // ibc_fifo
`default_nettype wire

// ---- ibc_bit_counter_sva.sv ----
// port assertions for the serial bit counter block
`default_nettype none
module ibc_bit_counter_sva (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sclIn,
   input wire logic txEmptyRequest,
   input wire logic txEndRequest
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   wire acc, enWr, clrWr, hole;
   // completed writes and address decode
   assign acc = psel && penable && pready && pwrite;
   assign enWr = acc && paddr == 12'h004;
   assign clrWr = enWr || (acc && paddr == 12'h008);
   assign hole = paddr > 12'h010 || paddr[1:0] != 2'b00;
   rst_quiet_a: assert property ($rose(rst_n) |-> !txEmptyRequest && !txEndRequest)
      else $error("request after reset");
   empty_gate_a: assert property (enWr && !pwdata[7] |=> !txEmptyRequest)
      else $error("empty request not gated");
   end_gate_a: assert property (enWr && !pwdata[6] |=> !txEndRequest)
      else $error("end request not gated");
   end_hold_a: assert property (txEndRequest && !clrWr |=> txEndRequest)
      else $error("end request dropped");
   end_src_a: assert property ($rose(txEndRequest) && !$past(enWr) |-> $past(sclIn, 2))
      else $error("end request without clock rise");
   protect_rd_a: assert property (psel && penable && !pwrite && paddr == 12'h000
      |-> prdata[5:3] == 3'b111) else $error("protect bit not one");
   no_wait_a: assert property (psel && penable && paddr != 12'h00C |-> pready)
      else $error("register access stalled");
   bad_addr_a: assert property (psel && penable && hole |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access not refused");
endmodule // ibc_bit_counter_sva
`default_nettype wire

// ---- ibc_peer_model.sv ----
// serial peer: clocks frames and answers the acknowledge
`default_nettype none
module ibc_peer_model (
   input wire logic sdaOe,
   input wire logic sdaOut,
   output logic sclIn,
   output wire logic sdaIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ackLow = 1'b0;
   // pulled-up line: follows the block while it drives, ack pulls it low
   assign sdaIn = (!sdaOe || sdaOut) && !ackLow;
   // clock rests low between frames, so count writes are legal
   initial sclIn = 1'b0;
   // n clock periods of 200 ns, 100 ns high; ack pulls the last slot low
   task automatic frame(input int n, input bit ack);
      #13;
      for (int i = 1; i <= n; i++) begin
         ackLow = ack && i == n;
         #100 sclIn = 1'b1;
         #100 sclIn = 1'b0;
      end
      ackLow = 1'b0;
   endtask
endmodule // ibc_peer_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial bit counter block
`default_nettype none
`include "ibc_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] MODE = `IBC_OFS_MODE, IEN = `IBC_OFS_IRQEN, STAT = `IBC_OFS_STATUS;
   localparam logic [11:0] TXD = `IBC_OFS_TXDATA, CTRL = `IBC_OFS_CTRL;
   logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdv;
   wire [31:0] prdata;
   wire pready, pslverr, sclIn, sdaIn, sdaOut, sdaOe, txEmptyRequest, txEndRequest;
   int err_total = 0, cmp_count = 0;
   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;
   ibc_bit_counter dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sclIn, .sdaIn, .sdaOut, .sdaOe, .txEmptyRequest, .txEndRequest);
   ibc_peer_model peer_u (.sdaOe, .sdaOut, .sclIn, .sdaIn);
   // one transfer; idle edge first so no strobe changes twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      // pready and read data taken at the rising edge that ends the access
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // register read compared as a whole word
   task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      cmp_count++;
      if (rdv !== {24'h00_0000, e}) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, rdv);
      end
   endtask
   // request and data pin compare
   task automatic pin(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence: registers, a two-wire frame, then sync frames through a full fifo
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd("ien", IEN, 8'h00);
      rd("mode", MODE, 8'h38);
      rd("hole", 12'h040, 8'h00);
      apb(1'b1, MODE, 8'h0F);
      rd("mode", MODE, 8'h38);
      apb(1'b1, MODE, 8'h03);
      rd("mode", MODE, 8'h3B);
      apb(1'b1, IEN, 8'hC0);
      @(negedge ref_clk) pin("empty", 1'b1, txEmptyRequest);
      $display("register test ended");
      apb(1'b1, TXD, 8'hA5);
      rd("left", MODE, 8'h3B);
      peer_u.frame(1, 1'b0);
      rd("left", MODE, 8'h3A);
      peer_u.frame(2, 1'b0);
      @(negedge ref_clk) pin("end", 1'b0, txEndRequest);
      peer_u.frame(1, 1'b1);
      @(negedge ref_clk) pin("end", 1'b1, txEndRequest);
      rd("mode", MODE, 8'h38);
      rd("stat", STAT, 8'hC0);
      apb(1'b1, IEN, 8'h80);
      @(negedge ref_clk) pin("end", 1'b0, txEndRequest);
      apb(1'b1, IEN, 8'hC0);
      @(negedge ref_clk) pin("end", 1'b1, txEndRequest);
      apb(1'b1, STAT, 8'h40);
      @(negedge ref_clk) pin("end", 1'b0, txEndRequest);
      $display("two-wire test ended");
      // count set before leaving two-wire format, never in sync format
      apb(1'b1, MODE, 8'h01);
      apb(1'b1, CTRL, 8'h00);
      for (int i = 0; i < 5; i++)
         apb(1'b1, TXD, 8'(i));
      @(negedge ref_clk) pin("empty", 1'b0, txEmptyRequest);
      // lsb-first for the queued bytes; protect set, so the count stays
      apb(1'b1, MODE, 8'h88);
      // a stalled push only finishes if the one-bit frame ends
      fork
         apb(1'b1, TXD, 8'h80);
         peer_u.frame(1, 1'b0);
      join
      repeat (4) peer_u.frame(8, 1'b0);
      peer_u.frame(7, 1'b0);
      @(negedge ref_clk) pin("end", 1'b0, txEndRequest);
      // seven falls put the last bit of the reversed byte on the pin
      repeat (6) @(negedge ref_clk);
      pin("data", 1'b1, sdaOut);
      peer_u.frame(1, 1'b0);
      @(negedge ref_clk) pin("end", 1'b1, txEndRequest);
      @(negedge ref_clk) pin("empty", 1'b1, txEmptyRequest);
      rd("mode", MODE, 8'hB8);
      apb(1'b1, IEN, 8'h00);
      @(negedge ref_clk) pin("empty", 1'b0, txEmptyRequest);
      $display("sync fifo test ended");
      results();
   end
   // hang guard, well past the roughly 12 us the tests need
   initial begin
      #200us;
      err_total++;
      $display("watchdog expired");
      results();
   end
endmodule // tb_top
bind ibc_bit_counter ibc_bit_counter_sva chk_u (.ref_clk, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .sclIn, .txEmptyRequest, .txEndRequest);
`default_nettype wire
